/* File: logic/rpfc_codec.v */
// Contract
// - Per-packet string starts with first 16 RTP header bits.
// - Then 16-bit big-endian packet length minus 12.
// - Then the 32-bit timestamp; SSRC is skipped.
// - Then every octet after the 12-byte fixed header.
// - Repair string is XOR of all protected packet strings.
// - Top two bits replaced by R and F flags; version 2 only.
// - Next bits: padding, extension, 4-bit CSRC count recovery.
// - Then marker recovery bit and 7-bit payload type recovery.
// - Then 16-bit length recovery and 32-bit timestamp recovery.
// - Sequence base is the lowest protected sequence number.
// - Masks written when F is zero, L and D when F is one.
// - Rest of XOR string is the repair payload after header.
// - Shorter packets padded with trailing zero octets.
// - No parity processing when R flag is set.
// - Bitmask needs R=F=0; mask is 15, 46 or 110 bits; the encoder mask word reads back only 15.
// - Mask bit i protects base plus i; index 0 is MSB.
// - Column set holds D packets, row set holds L packets; the header L/D walk visits D+1 and L+1.
// - Nonzero L: D>0 column protection, D=0 row protection.
// - Header offsets: D=0 consecutive to base+L; else step L.
// - F=1, L=D=0: use signaled L/D, payload type selects kind.
// - Signaled: base plus i times step, modulo 65536.
// - Output must match the recommended procedure bit for bit.
// - Signaled index runs below D interleaved, below L row.
//
// Our own choices: the APB interface to the registers and the register addresses.
`default_nettype none
`include "rpfc_regs.vh"
module rpfc_codec (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_resetn,
	input  wire        i_ce,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output reg  [31:0] o_prdata,
	output wire        o_pslverr,
	// Source packet stream, one octet per beat
	input  wire        i_src_valid,
	input  wire [7:0]  i_src_data,
	input  wire        i_src_last,
	input  wire [15:0] i_src_seq,
	output wire        o_src_ready
);
	// Packet octet positions of the first two header octets and the sequence number
	localparam P_B0 = 4'd0;
	localparam P_B1 = 4'd1;
	localparam P_S0 = 4'd2;
	localparam P_S1 = 4'd3;

	reg [31:0] pay_mem [0:`RPFC_PAY_WORDS-1];

	// Control and encoder state
	reg        r_flag_r;
	reg        f_flag_r;
	reg [1:0]  mask_sel_r;
	reg [7:0]  cfg_l_r;
	reg [7:0]  cfg_d_r;
	reg [109:0] enc_mask_r;
	reg [15:0] hdr01_r;
	reg [15:0] len_x_r;
	reg [31:0] ts_x_r;
	reg [15:0] base_r;
	reg        base_vld_r;
	reg [15:0] max_len_r;
	reg [7:0]  pkt_cnt_r;
	reg [10:0] pos_r;
	reg        err_r;
	// Decoder state
	reg [31:0] dec_hdr_r;
	reg [109:0] dec_mask_r;
	reg [15:0] sig_r;
	reg [6:0]  dec_pt_r;
	reg        dec_start_r;
	reg        dec_bad_r;
	reg        dec_next_r;

	// APB, zero wait state
	wire acc   = i_psel & i_penable;
	wire wr_en = acc & i_pwrite;
	wire rd_en = acc & ~i_pwrite;
	assign o_pready = 1'b1;
	wire pay_hit = i_paddr[11:10] == 2'b01;
	wire [7:0] pay_idx = i_paddr[9:2];

	function hit;
		input [11:0] a;
		input [11:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	function [6:0] mask_width;
		input [1:0] sel;
		begin
			case (sel)
			2'd0: mask_width = `RPFC_MASK_W0;
			2'd1: mask_width = `RPFC_MASK_W1;
			default: mask_width = `RPFC_MASK_W2;
			endcase
		end
	endfunction

	// Serial-number style comparison: a before b
	function seq_lt;
		input [15:0] a;
		input [15:0] b;
		reg   [15:0] diff;
		begin
			diff   = b - a;
			seq_lt = (diff != 16'h0000) && !diff[15];
		end
	endfunction

	wire known = hit(i_paddr, `RPFC_CTRL_OFF) |
		hit(i_paddr, `RPFC_ENC_CFG_OFF) | hit(i_paddr, `RPFC_ENC_STAT_OFF) |
		hit(i_paddr, `RPFC_ENC_BASE_OFF) | hit(i_paddr, `RPFC_ENC_HDR0_OFF) |
		hit(i_paddr, `RPFC_ENC_HDR1_OFF) |
		hit(i_paddr, `RPFC_ENC_MASKLD_OFF) |
		hit(i_paddr, `RPFC_DEC_HDR_OFF) | hit(i_paddr, `RPFC_DEC_MASK0_OFF) |
		hit(i_paddr, `RPFC_DEC_MASK1_OFF) |
		hit(i_paddr, `RPFC_DEC_MASK2_OFF) |
		hit(i_paddr, `RPFC_DEC_MASK3_OFF) | hit(i_paddr, `RPFC_DEC_SIG_OFF) |
		hit(i_paddr, `RPFC_DEC_CMD_OFF) | hit(i_paddr, `RPFC_DEC_STAT_OFF) |
		hit(i_paddr, `RPFC_DEC_SEQ_OFF) | pay_hit;
	assign o_pslverr = acc & ~known;

	wire clr_cmd = wr_en & hit(i_paddr, `RPFC_CTRL_OFF) & i_pwdata[0];

	// Source stream taking
	wire src_take = i_src_valid & o_src_ready & i_ce;
	// Stall while software clears or touches the payload buffer
	assign o_src_ready = ~r_flag_r & ~(acc & pay_hit);
	wire [10:0] pos_nxt = pos_r + 11'd1;
	wire in_pay = (pos_r >= 11'd12);
	wire [9:0] pay_off = pos_r[9:0] - 10'd12;
	// Payload octet k lands in word k/4, byte lane k%4
	wire [7:0] wr_word = pay_off[9:2];
	wire [1:0] wr_lane = pay_off[1:0];
	wire [15:0] pkt_len = {5'h00, pos_nxt};
	wire [15:0] len_field = pkt_len - `RPFC_RTP_FIXED_LEN;

	// Walker command from decoder registers
	wire dec_r = dec_hdr_r[31];
	wire dec_f = dec_hdr_r[30];
	wire [15:0] dec_base = dec_hdr_r[15:0];
	wire [7:0] dec_l = dec_hdr_r[23:16];
	wire [7:0] dec_d = dec_mask_r[7:0];
	wire ld_zero = (dec_l == 8'h00) && (dec_d == 8'h00);
	// Payload type picks signaled interleaved or row repair
	wire sig_il = (dec_pt_r == sig_r[15:9]);
	wire [1:0] wk_mode = !dec_f ? 2'd0 :
		(!ld_zero ? 2'd1 : (sig_il ? 2'd2 : 2'd3));
	wire [7:0] wk_l = (wk_mode[1]) ? sig_r[7:0] : dec_l;
	wire [7:0] wk_d = (wk_mode[1]) ? sig_d_r : dec_d;
	wire wk_busy;
	wire wk_vld;
	wire [15:0] wk_seq;
	wire wk_done;
	reg  [7:0] sig_d_r;

	rpfc_seq_walk u_walk (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_ce        (i_ce),
		.i_start     (dec_start_r),
		.i_mode      (wk_mode),
		.i_base      (dec_base),
		.i_l         (wk_l),
		.i_d         (wk_d),
		.i_mask      (dec_mask_r),
		.i_mask_w    (mask_width(dec_hdr_r[25:24])),
		.i_step_next (dec_next_r),
		.o_busy      (wk_busy),
		.o_seq_vld   (wk_vld),
		.o_seq       (wk_seq),
		.o_done      (wk_done)
	);

	// Byte lane XOR into payload buffer; unwritten tail stays zero
	wire [31:0] lane_x = {24'h000000, i_src_data} << {wr_lane, 3'b000};

	always @(posedge i_clk) begin
		if (i_ce && src_take && in_pay)
			pay_mem[wr_word] <= pay_mem[wr_word] ^ lane_x;
		else if (i_ce && wr_en && pay_hit)
			pay_mem[pay_idx] <= 32'h00000000;
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_flag_r    <= 1'b0;
			f_flag_r    <= 1'b0;
			mask_sel_r  <= 2'h0;
			cfg_l_r     <= 8'h00;
			cfg_d_r     <= 8'h00;
			enc_mask_r  <= 110'h0;
			hdr01_r     <= 16'h0000;
			len_x_r     <= 16'h0000;
			ts_x_r      <= 32'h00000000;
			base_r      <= 16'h0000;
			base_vld_r  <= 1'b0;
			max_len_r   <= 16'h0000;
			pkt_cnt_r   <= 8'h00;
			pos_r       <= 11'h000;
			err_r       <= 1'b0;
			dec_hdr_r   <= 32'h00000000;
			dec_mask_r  <= 110'h0;
			sig_r       <= 16'h0000;
			sig_d_r     <= 8'h00;
			dec_pt_r    <= 7'h00;
			dec_start_r <= 1'b0;
			dec_bad_r   <= 1'b0;
			dec_next_r  <= 1'b0;
		end else if (i_ce) begin
			dec_start_r <= 1'b0;
			dec_next_r  <= 1'b0;
			if (clr_cmd) begin
				hdr01_r    <= 16'h0000;
				len_x_r    <= 16'h0000;
				ts_x_r     <= 32'h00000000;
				base_vld_r <= 1'b0;
				max_len_r  <= 16'h0000;
				pkt_cnt_r  <= 8'h00;
				err_r      <= 1'b0;
			end
			if (wr_en) begin
				if (hit(i_paddr, `RPFC_ENC_CFG_OFF)) begin
					r_flag_r   <= i_pwdata[31];
					f_flag_r   <= i_pwdata[30];
					mask_sel_r <= i_pwdata[25:24];
					cfg_l_r    <= i_pwdata[15:8];
					cfg_d_r    <= i_pwdata[7:0];
				end
				if (hit(i_paddr, `RPFC_ENC_MASKLD_OFF))
					enc_mask_r <= {i_pwdata[31:0], enc_mask_r[109:32]};
				if (hit(i_paddr, `RPFC_DEC_HDR_OFF))
					dec_hdr_r <= i_pwdata;
				if (hit(i_paddr, `RPFC_DEC_MASK0_OFF))
					dec_mask_r[109:78] <= i_pwdata;
				if (hit(i_paddr, `RPFC_DEC_MASK1_OFF))
					dec_mask_r[77:46] <= i_pwdata;
				if (hit(i_paddr, `RPFC_DEC_MASK2_OFF))
					dec_mask_r[45:14] <= i_pwdata;
				if (hit(i_paddr, `RPFC_DEC_MASK3_OFF))
					dec_mask_r[13:0] <= i_pwdata[31:18];
				if (hit(i_paddr, `RPFC_DEC_SIG_OFF)) begin
					sig_r   <= i_pwdata[31:16];
					sig_d_r <= i_pwdata[7:0];
				end
				if (hit(i_paddr, `RPFC_DEC_CMD_OFF) && !wk_busy) begin
					dec_pt_r <= i_pwdata[6:0];
					// Only a set retransmission flag is refused; an F=0 mask is not checked
					if (dec_r)
						dec_bad_r <= 1'b1;
					else begin
						dec_bad_r   <= 1'b0;
						dec_start_r <= 1'b1;
					end
				end
				if (hit(i_paddr, `RPFC_DEC_CMD_OFF) && i_pwdata[8])
					dec_next_r <= 1'b1;
			end
			if (src_take) begin
				pos_r <= i_src_last ? 11'h000 : pos_nxt;
				case (pos_r[3:0])
				P_B0: if (pos_r[10:4] == 7'h00)
					hdr01_r[15:8] <= hdr01_r[15:8] ^ i_src_data;
				P_B1: if (pos_r[10:4] == 7'h00)
					hdr01_r[7:0] <= hdr01_r[7:0] ^ i_src_data;
				4'd4: if (pos_r[10:4] == 7'h00)
					ts_x_r[31:24] <= ts_x_r[31:24] ^ i_src_data;
				4'd5: if (pos_r[10:4] == 7'h00)
					ts_x_r[23:16] <= ts_x_r[23:16] ^ i_src_data;
				4'd6: if (pos_r[10:4] == 7'h00)
					ts_x_r[15:8] <= ts_x_r[15:8] ^ i_src_data;
				4'd7: if (pos_r[10:4] == 7'h00)
					ts_x_r[7:0] <= ts_x_r[7:0] ^ i_src_data;
				default: ;
				endcase
				if (i_src_last) begin
					len_x_r   <= len_x_r ^ len_field;
					pkt_cnt_r <= pkt_cnt_r + 8'h01;
					if (pkt_len < `RPFC_RTP_FIXED_LEN)
						err_r <= 1'b1;
					if (len_field > max_len_r)
						max_len_r <= len_field;
					// Lowest sequence number in wrap-safe order
					if (!base_vld_r || seq_lt(i_src_seq, base_r)) begin
						base_r     <= i_src_seq;
						base_vld_r <= 1'b1;
					end
				end
			end
		end
	end

	// FEC header word 0: R, F, P, X, CC, M, PT, length recovery
	wire [31:0] hdr0 = {r_flag_r, f_flag_r,
		hdr01_r[13], hdr01_r[12], hdr01_r[11:8],
		hdr01_r[7], hdr01_r[6:0],
		len_x_r};
	// Mask word when F=0, L and D when F=1
	wire [31:0] ld_word = f_flag_r ? {16'h0000, cfg_l_r, cfg_d_r} :
		{enc_mask_r[109:95], 17'h00000};

	always @* begin
		o_prdata = 32'h00000000;
		if (rd_en) begin
			if (pay_hit)
				o_prdata = pay_mem[pay_idx];
			else if (hit(i_paddr, `RPFC_ENC_CFG_OFF))
				o_prdata = {r_flag_r, f_flag_r, 4'h0, mask_sel_r,
					8'h00, cfg_l_r, cfg_d_r};
			else if (hit(i_paddr, `RPFC_ENC_STAT_OFF))
				o_prdata = {max_len_r, pkt_cnt_r, 7'h00, err_r};
			else if (hit(i_paddr, `RPFC_ENC_BASE_OFF))
				o_prdata = {base_vld_r, 15'h0000, base_r};
			else if (hit(i_paddr, `RPFC_ENC_HDR0_OFF))
				o_prdata = hdr0;
			else if (hit(i_paddr, `RPFC_ENC_HDR1_OFF))
				o_prdata = ts_x_r;
			else if (hit(i_paddr, `RPFC_ENC_MASKLD_OFF))
				o_prdata = ld_word;
			else if (hit(i_paddr, `RPFC_DEC_HDR_OFF))
				o_prdata = dec_hdr_r;
			else if (hit(i_paddr, `RPFC_DEC_SIG_OFF))
				o_prdata = {sig_r, 8'h00, sig_d_r};
			else if (hit(i_paddr, `RPFC_DEC_STAT_OFF))
				o_prdata = {27'h0000000, wk_mode, dec_bad_r, wk_done,
					wk_busy};
			else if (hit(i_paddr, `RPFC_DEC_SEQ_OFF))
				o_prdata = {15'h0000, wk_vld, wk_seq};
			else
				o_prdata = 32'h00000000;
		end
	end
endmodule
`default_nettype wire

/* File: logic/rpfc_regs.vh */
`ifndef RPFC_REGS_VH
`define RPFC_REGS_VH
// Register byte offsets
`define RPFC_CTRL_OFF       12'h000
`define RPFC_ENC_CFG_OFF    12'h004
`define RPFC_ENC_STAT_OFF   12'h008
`define RPFC_ENC_BASE_OFF   12'h00c
`define RPFC_ENC_HDR0_OFF   12'h010
`define RPFC_ENC_HDR1_OFF   12'h014
`define RPFC_ENC_MASKLD_OFF 12'h018
`define RPFC_DEC_HDR_OFF    12'h020
`define RPFC_DEC_MASK0_OFF  12'h024
`define RPFC_DEC_MASK1_OFF  12'h028
`define RPFC_DEC_MASK2_OFF  12'h02c
`define RPFC_DEC_MASK3_OFF  12'h030
`define RPFC_DEC_SIG_OFF    12'h034
`define RPFC_DEC_CMD_OFF    12'h038
`define RPFC_DEC_STAT_OFF   12'h03c
`define RPFC_DEC_SEQ_OFF    12'h040
`define RPFC_PAY_BASE_OFF   12'h400
`define RPFC_PAY_WORDS      256
`define RPFC_RTP_FIXED_LEN  16'h000c
`define RPFC_MOD_SEQ        16
// Mask widths
`define RPFC_MASK_W0        7'd15
`define RPFC_MASK_W1        7'd46
`define RPFC_MASK_W2        7'd110
`endif

/* File: logic/rpfc_seq_walk.v */
`default_nettype none
// Walks the protected sequence numbers of one repair packet
module rpfc_seq_walk (
	// Clock and reset
	input  wire         i_clk,
	input  wire         i_resetn,
	input  wire         i_ce,
	// Command
	input  wire         i_start,
	input  wire [1:0]   i_mode,
	input  wire [15:0]  i_base,
	input  wire [7:0]   i_l,
	input  wire [7:0]   i_d,
	input  wire [109:0] i_mask,
	input  wire [6:0]   i_mask_w,
	input  wire         i_step_next,
	// Result
	output wire         o_busy,
	output reg          o_seq_vld,
	output reg  [15:0]  o_seq,
	output reg          o_done
);
	// Modes: 0 mask, 1 header L/D, 2 signaled interleaved, 3 signaled row
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN  = 2'd1;
	localparam ST_OUT  = 2'd2;

	reg [1:0]  st_r;
	reg [6:0]  idx_r;
	reg [7:0]  last_r;
	reg [15:0] step_r;
	reg [15:0] cur_r;
	reg [1:0]  mode_r;
	reg [6:0]  mw_r;
	reg [109:0] mask_r;

	assign o_busy = (st_r != ST_IDLE);

	wire mask_hit = mask_r[7'd109 - idx_r];
	wire [6:0] idx_inc = idx_r + 7'd1;

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r      <= ST_IDLE;
			idx_r     <= 7'h00;
			last_r    <= 8'h00;
			step_r    <= 16'h0000;
			cur_r     <= 16'h0000;
			mode_r    <= 2'h0;
			mw_r      <= 7'h00;
			mask_r    <= 110'h0;
			o_seq_vld <= 1'b0;
			o_seq     <= 16'h0000;
			o_done    <= 1'b0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			case (st_r)
			ST_IDLE: begin
				if (i_start) begin
					mode_r <= i_mode;
					cur_r  <= i_base;
					idx_r  <= 7'h00;
					mw_r   <= i_mask_w;
					// Mask arrives left-aligned: index 0 is bit 109
					mask_r <= i_mask;
					case (i_mode)
					2'd1: begin
						step_r <= (i_d == 8'h00) ? 16'h0001 : {8'h00, i_l};
						last_r <= (i_d == 8'h00) ? i_l : i_d;
					end
					2'd2: begin
						step_r <= {8'h00, i_l};
						last_r <= i_d - 8'h01;
					end
					2'd3: begin
						step_r <= 16'h0001;
						last_r <= i_l - 8'h01;
					end
					default: begin
						step_r <= 16'h0001;
						last_r <= 8'h00;
					end
					endcase
					st_r <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (mode_r == 2'd0) begin
					if (idx_r == mw_r) begin
						st_r   <= ST_IDLE;
						o_done <= 1'b1;
					end else if (mask_hit) begin
						o_seq     <= cur_r;
						o_seq_vld <= 1'b1;
						st_r      <= ST_OUT;
					end else begin
						idx_r <= idx_inc;
						cur_r <= cur_r + 16'h0001;
					end
				end else begin
					// Sum wraps modulo 65536 by width
					o_seq     <= cur_r;
					o_seq_vld <= 1'b1;
					st_r      <= ST_OUT;
				end
			end
			ST_OUT: begin
				if (i_step_next) begin
					o_seq_vld <= 1'b0;
					if (mode_r != 2'd0 && {1'b0, idx_r} == last_r) begin
						st_r   <= ST_IDLE;
						o_done <= 1'b1;
					end else begin
						idx_r <= idx_inc;
						cur_r <= cur_r + step_r;
						st_r  <= ST_RUN;
					end
				end
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: verif/rpfc_codec_checker.sv */
`default_nettype none
`include "rpfc_regs.vh"
module rpfc_chk (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_ce,
	// APB
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic        o_pready,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pslverr,
	// Source stream
	input  wire logic        i_src_valid,
	input  wire logic [7:0]  i_src_data,
	input  wire logic        i_src_last,
	input  wire logic [15:0] i_src_seq,
	input  wire logic        o_src_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	logic r_flag_r;
	assign acc = i_psel & i_penable;
	// Shadow of the retransmission flag in the encoder setup
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			r_flag_r <= 1'b0;
		else if (i_ce && acc && i_pwrite && i_paddr == `RPFC_ENC_CFG_OFF)
			r_flag_r <= i_pwdata[31];
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	pready_high_a: assert property (o_pready)
		else $error("pready not high");
	rdata_idle_a: assert property (!(acc && !i_pwrite) |-> o_prdata == 32'h0)
		else $error("read data outside a read");
	err_phase_a: assert property (o_pslverr |-> acc)
		else $error("slave error outside access");
	err_unmap_a: assert property (acc && i_paddr == 12'h044 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
		else $error("unmapped access not refused");
	map_ok_a: assert property (acc && i_paddr == `RPFC_DEC_STAT_OFF |-> !o_pslverr)
		else $error("mapped access refused");
	rflag_stall_a: assert property (r_flag_r |-> !o_src_ready)
		else $error("stream taken with retransmit flag");
	paywin_stall_a: assert property (acc && i_paddr[11:10] == 2'b01 |-> !o_src_ready)
		else $error("stream open during payload access");
	cfg_write_a: assert property (i_ce && acc && i_pwrite && i_paddr == `RPFC_ENC_CFG_OFF && i_pwdata[31] |=> !o_src_ready [*2])
		else $error("retransmit setup did not stall");
	cover property (acc && o_pslverr);
	cover property (i_src_valid && o_src_ready && i_src_last);
	cover property (r_flag_r && i_psel);
endmodule
bind rpfc_codec rpfc_chk rpfc_chk_inst (.i_clk(i_clk), .i_resetn(i_resetn),
	.i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
	.o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_src_valid(i_src_valid),
	.i_src_data(i_src_data), .i_src_last(i_src_last), .i_src_seq(i_src_seq),
	.o_src_ready(o_src_ready));
`default_nettype wire

/* File: verif/rpfc_src_model.sv */
`default_nettype none
module rpfc_src_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Stream
	input  wire logic        i_ready,
	output var  logic        o_valid,
	output var  logic [7:0]  o_data,
	output var  logic        o_last,
	output var  logic [15:0] o_seq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic stuck = 1'b0;
	initial begin
		o_valid = 1'b0;
		o_data = 8'h00;
		o_last = 1'b0;
		o_seq = 16'h0000;
	end
	// Whole packet in wire order, pausing every third octet
	task automatic send_pkt(input logic [7:0] pkt[$], input logic [15:0] s);
		int n;
		for (int k = 0; k < pkt.size(); k++) begin
			o_valid <= 1'b1;
			o_data <= pkt[k];
			o_last <= (k == pkt.size() - 1);
			o_seq <= s;
			n = 0;
			do begin
				@(posedge i_clk);
				n++;
			end while (i_ready !== 1'b1 && n < 64);
			if (n >= 64)
				stuck = 1'b1;
			if (k % 3 == 2 || k == pkt.size() - 1) begin
				// Released lines show a changed value, not the last one
				o_valid <= 1'b0;
				o_data <= ~pkt[k];
				o_seq <= ~s;
				o_last <= 1'b0;
				@(posedge i_clk);
			end
		end
	endtask
endmodule
`default_nettype wire

/* File: verif/rtp_parity_fec_codec_test.sv */
`default_nettype none
`include "rpfc_regs.vh"
module rtp_parity_fec_codec_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'b0;
	logic             resetn = 1'b0;
	logic             psel = 1'b0;
	logic             pen = 1'b0;
	logic             pwr = 1'b0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0;
	logic [31:0]      rd;
	logic             er;
	wire logic        pready;
	wire logic        pslverr;
	wire logic        sv;
	wire logic        sl;
	wire logic        sr;
	wire logic [31:0] prdata;
	wire logic [7:0]  sd;
	wire logic [15:0] sq;
	int               failures = 0;
	int               check_count = 0;
	always #20 clk = ~clk;
	rpfc_codec rpfc_codec_inst (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_src_valid(sv), .i_src_data(sd),
		.i_src_last(sl), .i_src_seq(sq), .o_src_ready(sr));
	rpfc_src_model rpfc_src_model_inst (.i_clk(clk), .i_resetn(resetn),
		.i_ready(sr), .o_valid(sv), .o_data(sd), .o_last(sl), .o_seq(sq));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 16) begin
			failures++;
			wrap_up();
		end
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e, "register read");
	endtask
	task automatic t_reset();
		rdk(`RPFC_ENC_BASE_OFF, 32'hffffffff, 32'h0);
		rdk(`RPFC_DEC_STAT_OFF, 32'h00000007, 32'h0);
	endtask
	task automatic t_unmapped();
		wr(12'h044, 32'hffffffff);
		chk({31'h0, er}, 32'h1, "unmapped write");
		apb(1'b0, 12'h044, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
	endtask
	task automatic t_encode();
		logic [7:0] pa[$];
		logic [7:0] pb[$];
		pa = '{8'h80, 8'h60, 8'hff, 8'hfe, 8'h11, 8'h22, 8'h33, 8'h44,
			8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h01, 8'h02, 8'h03, 8'h04};
		pb = '{8'ha3, 8'he5, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h04,
			8'hdd, 8'hee, 8'hff, 8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60};
		wr(`RPFC_CTRL_OFF, 32'h1);
		wr(`RPFC_PAY_BASE_OFF, 32'h0);
		wr(`RPFC_PAY_BASE_OFF + 12'h4, 32'h0);
		wr(`RPFC_PAY_BASE_OFF + 12'h8, 32'h0);
		wr(`RPFC_ENC_CFG_OFF, 32'h40000302);
		rpfc_src_model_inst.send_pkt(pb, 16'h0001);
		rpfc_src_model_inst.send_pkt(pa, 16'hfffe);
		chk({31'h0, rpfc_src_model_inst.stuck}, 32'h0, "stream stuck");
		if (rpfc_src_model_inst.stuck)
			wrap_up();
		rdk(`RPFC_ENC_HDR0_OFF, 32'hffffffff, 32'h63850002);
		rdk(`RPFC_ENC_HDR1_OFF, 32'hffffffff, 32'h10203040);
		rdk(`RPFC_ENC_BASE_OFF, 32'h8000ffff, 32'h8000fffe);
		rdk(`RPFC_ENC_STAT_OFF, 32'hffffff01, 32'h00060200);
		rdk(`RPFC_ENC_MASKLD_OFF, 32'hffffffff, 32'h00000302);
		rdk(`RPFC_PAY_BASE_OFF, 32'hffffffff, 32'h44332211);
		rdk(`RPFC_PAY_BASE_OFF + 12'h4, 32'hffffffff, 32'h00006050);
		rdk(`RPFC_PAY_BASE_OFF + 12'h8, 32'hffffffff, 32'h0);
	endtask
	task automatic t_refuse();
		wr(`RPFC_ENC_CFG_OFF, 32'h80000000);
		chk({31'h0, sr}, 32'h0, "stream open with retransmit");
		wr(`RPFC_DEC_HDR_OFF, 32'h80000000);
		wr(`RPFC_DEC_CMD_OFF, 32'h0);
		rdk(`RPFC_DEC_STAT_OFF, 32'h4, 32'h4);
		wr(`RPFC_ENC_CFG_OFF, 32'h0);
		chk({31'h0, sr}, 32'h1, "stream closed");
		wr(`RPFC_ENC_MASKLD_OFF, 32'hc0020000);
		rdk(`RPFC_ENC_MASKLD_OFF, 32'hffffffff, 32'hc0020000);
	endtask
	task automatic dec_run(input logic [31:0] h, m0, m1, m3, s,
		input logic [6:0] pt, input int n, input logic [63:0] e);
		int w;
		wr(`RPFC_DEC_HDR_OFF, h);
		wr(`RPFC_DEC_MASK0_OFF, m0);
		wr(`RPFC_DEC_MASK1_OFF, m1);
		wr(`RPFC_DEC_MASK2_OFF, 32'h0);
		wr(`RPFC_DEC_MASK3_OFF, m3);
		wr(`RPFC_DEC_SIG_OFF, s);
		wr(`RPFC_DEC_CMD_OFF, {25'h0, pt});
		for (int k = 0; k < n; k++) begin
			w = 0;
			do begin
				apb(1'b0, `RPFC_DEC_SEQ_OFF, 32'h0);
				w++;
			end while (rd[16] !== 1'b1 && w < 64);
			chk(rd & 32'h1ffff, {15'h0, 1'b1, e[16*k +: 16]}, "walk seq");
			if (rd[16] !== 1'b1)
				wrap_up();
			wr(`RPFC_DEC_CMD_OFF, {23'h0, 1'b1, 1'b0, pt});
		end
		w = 0;
		do begin
			apb(1'b0, `RPFC_DEC_STAT_OFF, 32'h0);
			w++;
		end while (rd[0] !== 1'b0 && w < 16);
		chk({31'h0, rd[0]}, 32'h0, "walk count");
		if (rd[0] !== 1'b0)
			wrap_up();
	endtask
	task automatic t_dec_mask();
		dec_run(32'h0000fffd, 32'ha0020000, 0, 0, 0, 0, 3, 64'h000b_fffffffd);
		dec_run(32'h01000100, 32'h80000000, 32'h00040000, 0, 0, 0, 2, 64'h012d0100);
		dec_run(32'h02000200, 32'h80000000, 0, 32'h00040000, 0, 0, 2, 64'h026d0200);
	endtask
	task automatic t_dec_hdr();
		dec_run(32'h40030010, 0, 0, 0, 0, 0, 4, 64'h0013001200110010);
		dec_run(32'h40030010, 0, 0, 32'h00080000, 0, 0, 3, 64'h0016_00130010);
	endtask
	task automatic t_dec_sig();
		dec_run(32'h4000fffe, 0, 0, 0, 32'hc2040003, 7'h61, 3, 64'h0006_0002fffe);
		dec_run(32'h4000fffe, 0, 0, 0, 32'hc2040003, 7'h62, 4, 64'h00010000fffffffe);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_unmapped();
		t_encode();
		t_refuse();
		t_dec_mask();
		t_dec_hdr();
		t_dec_sig();
		wrap_up();
	end
endmodule
`default_nettype wire
